// *** pdccr_top.sv ***
// device capability and device control/status registers of one switch port, wishbone slave
// What this block does
// - supported payload resets from strap: 001/010
// - supported payload read-only, override up to 512
// - phantom functions supported reads zero
// - extended tag supported reads zero
// - acceptable latency fields read-only zero
// - role-based error bit resets one, overridable
// - upstream captures slot power limit value
// - upstream captures slot power limit scale
// - four error reporting enables, writable, reset zero
// - relaxed ordering enable reads zero
// - max payload writable, clamped to supported
// - extended tag and phantom enables read zero
// - sticky aux power enable, writable, reset zero
// - no snoop enable reads zero
// - max read request size hardwired zero
// - errors logged in status regardless of enables
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pdccr_regs.svh"

module pdccr_top
   import pdccr_pkg::*;
#(
   parameter logic IS_UPSTREAM = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic ce_i,
   input wire pdccr_wb_req_type wb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic payload_512_strap_i,
   input wire pdccr_override_type ovr_i,
   input wire pdccr_spl_type spl_i,
   input wire logic [3:0] err_det_i,
   input wire logic aux_pwr_det_i,
   output logic [3:0] err_report_en_o,
   output logic [2:0] max_payload_o,
   output logic aux_pwr_en_o,
   output logic [2:0] mps_supported_o,
   output logic [3:0] err_status_o
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   pdccr_state_type st_ff; // registered state
   pdccr_state_type nxt_st; // next state
   logic any_rst; // either reset is active
   logic req; // a bus cycle is presented
   logic wr_cap; // write strobe at the capability word
   logic wr_ctl; // write strobe at the control/status word
   logic rd_cap; // address hits the capability word
   logic rd_ctl; // address hits the control/status word
   logic [2:0] ovr_mps; // override value limited to 512 bytes
   logic [2:0] sup_next; // supported payload after this cycle
   logic [2:0] mps_cand; // payload setting before clamping
   logic [2:0] mps_lim; // payload setting after clamping
   logic [31:0] cap_word; // assembled capability word
   logic [31:0] ctl_word; // assembled control/status word
   logic [3:0] err_clr; // write-one-to-clear strobes

   assign any_rst = rst_i || por_i;
   assign req = wb_i.cyc && wb_i.stb;
   assign rd_cap = (wb_i.adr[7:2] == `PDCCR_IDX_CAP);
   assign rd_ctl = (wb_i.adr[7:2] == `PDCCR_IDX_CTL);
   // a write takes effect at the edge where the master samples ack
   assign wr_cap = ce_i && req && wb_i.we && st_ff.ack && rd_cap;
   assign wr_ctl = ce_i && req && wb_i.we && st_ff.ack && rd_ctl;

   // ****************************************************************
   // payload clamps
   // ****************************************************************
   // an override can never advertise more than the port supports
   pdccr_clamp #(
      .W(3)
   ) u_ovr_clamp (
      .val_i(ovr_i.mps_sup),
      .limit_i(`PDCCR_MPS_512),
      .res_o(ovr_mps)
   );

   assign sup_next = (ce_i && ovr_i.wr) ? ovr_mps : st_ff.mps_sup;
   // the setting is re-clamped whenever the supported value shrinks too
   assign mps_cand = (wr_ctl && wb_i.sel[0]) ?
      wb_i.dat[`PDCCR_CTL_MPS_LSB +: 3] : st_ff.mps;

   pdccr_clamp #(
      .W(3)
   ) u_mps_clamp (
      .val_i(mps_cand),
      .limit_i(sup_next),
      .res_o(mps_lim)
   );

   // ****************************************************************
   // logged error flags
   // ****************************************************************
   // one flag per error class; enables do not gate logging
   for (genvar gi = 0; gi < 4; gi++) begin : g_err
      assign err_clr[gi] = wr_ctl && wb_i.sel[2] && wb_i.dat[`PDCCR_STS_ERR_LSB + gi];
      pdccr_flag #(
         .RESET_VAL(1'b0)
      ) u_flag (
         .clk_i(clk_i),
         .rst_i(any_rst),
         .ce_i(ce_i),
         .set_i(err_det_i[gi]),
         .clr_i(err_clr[gi]),
         .flag_o(err_status_o[gi])
      );
   end

   // ****************************************************************
   // read words
   // ****************************************************************
   // every bit not named here reads zero, hardwired or reserved
   always_comb begin
      cap_word = 32'h0000_0000;
      cap_word[`PDCCR_CAP_MPS_LSB +: 3] = st_ff.mps_sup;
      cap_word[`PDCCR_CAP_RBER] = st_ff.rber;
      cap_word[`PDCCR_CAP_SPLV_LSB +: 8] = st_ff.spl_val;
      cap_word[`PDCCR_CAP_SPLS_LSB +: 2] = st_ff.spl_scl;
   end

   // relaxed ordering, tag, phantom, no snoop and read size stay zero
   always_comb begin
      ctl_word = 32'h0000_0000;
      ctl_word[`PDCCR_CTL_ERREN_LSB +: 4] = st_ff.err_en;
      ctl_word[`PDCCR_CTL_MPS_LSB +: 3] = st_ff.mps;
      ctl_word[`PDCCR_CTL_AUX] = st_ff.aux_en;
      ctl_word[`PDCCR_STS_ERR_LSB +: 4] = err_status_o;
      ctl_word[`PDCCR_STS_AUXDET] = st_ff.aux_det;
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      nxt_st = st_ff;
      if (any_rst) begin
         // strap is taken by the clocked reset, never asynchronously
         nxt_st.ack = 1'b0;
         nxt_st.rdat = 32'h0000_0000;
         nxt_st.mps_sup = payload_512_strap_i ? `PDCCR_MPS_512 : `PDCCR_MPS_SUP_256;
         nxt_st.rber = `PDCCR_RST_RBER;
         nxt_st.spl_val = `PDCCR_RST_SPLV;
         nxt_st.spl_scl = `PDCCR_RST_SPLS;
         nxt_st.err_en = `PDCCR_RST_ERREN;
         nxt_st.mps = `PDCCR_RST_MPS;
         nxt_st.aux_det = `PDCCR_RST_AUXDET;
         // the sticky enable survives an ordinary reset
         if (por_i) begin
            nxt_st.aux_en = `PDCCR_RST_AUX;
         end
      end else begin
         // bus answer: ack one cycle after the request, drop it next cycle
         nxt_st.ack = req && !st_ff.ack;
         if (req && !st_ff.ack) begin
            if (rd_cap) begin
               nxt_st.rdat = cap_word;
            end else if (rd_ctl) begin
               nxt_st.rdat = ctl_word;
            end else begin
               // unmapped address answers with zero
               nxt_st.rdat = 32'h0000_0000;
            end
         end else begin
            nxt_st.rdat = 32'h0000_0000;
         end
         // capability is read-only to the bus; wr_cap is deliberately ignored
         nxt_st.mps_sup = sup_next;
         if (ovr_i.wr) begin
            nxt_st.rber = ovr_i.rber;
         end
         // downstream ports leave the captured limit at zero
         if (IS_UPSTREAM && spl_i.valid) begin
            nxt_st.spl_val = spl_i.value;
            nxt_st.spl_scl = spl_i.scale;
         end
         if (wr_ctl && wb_i.sel[0]) begin
            nxt_st.err_en = wb_i.dat[`PDCCR_CTL_ERREN_LSB +: 4];
         end
         nxt_st.mps = mps_lim;
         if (wr_ctl && wb_i.sel[1]) begin
            nxt_st.aux_en = wb_i.dat[`PDCCR_CTL_AUX];
         end
         nxt_st.aux_det = aux_pwr_det_i;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   // low clock enable freezes everything except a reset
   always_ff @(posedge clk_i) begin
      if (any_rst || ce_i) begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.rdat;
   assign err_report_en_o = st_ff.err_en;
   assign max_payload_o = st_ff.mps;
   assign aux_pwr_en_o = st_ff.aux_en;
   assign mps_supported_o = st_ff.mps_sup;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || por_i);

   // supported payload right after release follows the strap
   property p_strap;
      $past(rst_i || por_i) |->
         mps_supported_o == ($past(payload_512_strap_i) ? `PDCCR_MPS_512 : `PDCCR_MPS_SUP_256);
   endproperty
   a_strap: assert property (p_strap) else $error("strap payload reset wrong");

   // override lands limited to 512 bytes
   property p_override;
      ce_i && ovr_i.wr |=>
         mps_supported_o == (($past(ovr_i.mps_sup) > `PDCCR_MPS_512) ?
         `PDCCR_MPS_512 : $past(ovr_i.mps_sup));
   endproperty
   a_override: assert property (p_override) else $error("override not applied");

   // phantom and tag support bits read zero
   property p_cap_zero;
      wb_ack_o && rd_cap && !wb_i.we |-> wb_dat_o[5:3] == 3'h0;
   endproperty
   a_cap_zero: assert property (p_cap_zero) else $error("cap bits 5:3 not zero");

   // latency fields read zero
   property p_cap_lat;
      wb_ack_o && rd_cap && !wb_i.we |-> wb_dat_o[11:6] == 6'h00;
   endproperty
   a_cap_lat: assert property (p_cap_lat) else $error("latency fields not zero");

   // role-based error bit reads one after release
   property p_rber;
      $past(rst_i || por_i) |-> st_ff.rber == 1'b1;
   endproperty
   a_rber: assert property (p_rber) else $error("role based bit not one");

   // slot power limit message captured on the next edge
   property p_spl;
      IS_UPSTREAM && ce_i && spl_i.valid |=>
         st_ff.spl_val == $past(spl_i.value) && st_ff.spl_scl == $past(spl_i.scale);
   endproperty
   a_spl: assert property (p_spl) else $error("slot power limit not captured");

   // error reporting enables take the written byte
   property p_erren;
      wr_ctl && wb_i.sel[0] |=> err_report_en_o == $past(wb_i.dat[3:0]);
   endproperty
   a_erren: assert property (p_erren) else $error("error enables not written");

   // payload setting never above the supported value
   property p_mps_clamp;
      ##1 max_payload_o <= mps_supported_o;
   endproperty
   a_mps_clamp: assert property (p_mps_clamp) else $error("payload setting above supported");

   // hardwired control bits read zero
   property p_ctl_zero;
      wb_ack_o && rd_ctl && !wb_i.we |-> wb_dat_o[15:11] == 5'h00 && wb_dat_o[9:8] == 2'h0
         && wb_dat_o[4] == 1'b0 && wb_dat_o[31:21] == 11'h000;
   endproperty
   a_ctl_zero: assert property (p_ctl_zero) else $error("hardwired control bits set");

   // aux enable follows a write of its byte lane
   property p_aux_wr;
      wr_ctl && wb_i.sel[1] |=> aux_pwr_en_o == $past(wb_i.dat[10]);
   endproperty
   a_aux_wr: assert property (p_aux_wr) else $error("aux enable not written");

   // logged errors are set on the next edge
   property p_err_log;
      ce_i && err_det_i != 4'h0 |=> (err_status_o & $past(err_det_i)) == $past(err_det_i);
   endproperty
   a_err_log: assert property (p_err_log) else $error("detected error not logged");

   // ordinary reset keeps the sticky enable
   property p_sticky;
      @(posedge clk_i) disable iff (por_i) rst_i |=> aux_pwr_en_o == $past(aux_pwr_en_o);
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky aux enable lost");

   // power-on reset leaves the sticky enable cleared at release
   property p_aux_por;
      $fell(por_i) |-> aux_pwr_en_o == 1'b0;
   endproperty
   a_aux_por: assert property (p_aux_por) else $error("aux enable not cleared");

   // reserved capability bits read zero
   property p_cap_rsvd;
      wb_ack_o && rd_cap && !wb_i.we |->
         wb_dat_o[14:12] == 3'h0 && wb_dat_o[17:16] == 2'h0 && wb_dat_o[31:28] == 4'h0;
   endproperty
   a_cap_rsvd: assert property (p_cap_rsvd) else $error("reserved cap bits set");

   // extended tag support bit reads zero on its own
   property p_tag_sup;
      wb_ack_o && rd_cap && !wb_i.we |-> wb_dat_o[5] == 1'b0;
   endproperty
   a_tag_sup: assert property (p_tag_sup) else $error("tag support bit set");

   // a bus write at the capability word changes nothing
   property p_cap_ro;
      wr_cap && !ovr_i.wr |=>
         mps_supported_o == $past(mps_supported_o) && st_ff.rber == $past(st_ff.rber);
   endproperty
   a_cap_ro: assert property (p_cap_ro) else $error("capability changed by write");

   // slot power limit scale captured on the next edge
   property p_spl_scl;
      IS_UPSTREAM && ce_i && spl_i.valid |=> st_ff.spl_scl == $past(spl_i.scale);
   endproperty
   a_spl_scl: assert property (p_spl_scl) else $error("power scale not captured");

   // a downstream port never holds a captured limit
   property p_spl_dn;
      !IS_UPSTREAM |-> st_ff.spl_val == 8'h00 && st_ff.spl_scl == 2'h0;
   endproperty
   a_spl_dn: assert property (p_spl_dn) else $error("downstream limit not zero");

   // a written payload setting is stored, limited to the supported value
   property p_mps_wr;
      wr_ctl && wb_i.sel[0] && !ovr_i.wr |=> max_payload_o ==
         (($past(wb_i.dat[7:5]) > mps_supported_o) ? mps_supported_o : $past(wb_i.dat[7:5]));
   endproperty
   a_mps_wr: assert property (p_mps_wr) else $error("payload write not clamped");

   // a write of one clears a flag when no new error lands with it
   property p_w1c;
      (err_clr & ~err_det_i) != 4'h0 |=> (err_status_o & $past(err_clr & ~err_det_i)) == 4'h0;
   endproperty
   a_w1c: assert property (p_w1c) else $error("error flag not cleared");

endmodule : pdccr_top

`default_nettype wire

// *** pdccr_regs.svh ***
// register offsets, field positions, reset values and figures of the device capability/control bank
`ifndef PDCCR_REGS_SVH
`define PDCCR_REGS_SVH

// ****************************************************************
// register byte offsets and word indices
// ****************************************************************
`define PDCCR_OFS_CAP 8'hc4
`define PDCCR_OFS_CTL 8'hc8
`define PDCCR_IDX_CAP 6'h31
`define PDCCR_IDX_CTL 6'h32

// ****************************************************************
// capability word field positions
// ****************************************************************
`define PDCCR_CAP_MPS_LSB 0
`define PDCCR_CAP_RBER 15
`define PDCCR_CAP_SPLV_LSB 18
`define PDCCR_CAP_SPLS_LSB 26

// ****************************************************************
// control and status word field positions
// ****************************************************************
`define PDCCR_CTL_ERREN_LSB 0
`define PDCCR_CTL_MPS_LSB 5
`define PDCCR_CTL_AUX 10
`define PDCCR_STS_ERR_LSB 16
`define PDCCR_STS_AUXDET 20

// ****************************************************************
// reset values and limits
// ****************************************************************
`define PDCCR_MPS_SUP_256 3'h1
`define PDCCR_MPS_512 3'h2
`define PDCCR_RST_RBER 1'b1
`define PDCCR_RST_MPS 3'h0
`define PDCCR_RST_ERREN 4'h0
`define PDCCR_RST_SPLV 8'h00
`define PDCCR_RST_SPLS 2'h0
`define PDCCR_RST_AUX 1'b0
`define PDCCR_RST_AUXDET 1'b1

`endif

// *** pdccr_pkg.sv ***
// types shared by the device capability/control register bank
package pdccr_pkg;

   // classic wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pdccr_wb_req_type;

   // management bus or eeprom autoload override of advertised capability
   typedef struct packed {
      logic wr;
      logic [2:0] mps_sup;
      logic rber;
   } pdccr_override_type;

   // fields of a received slot power limit message
   typedef struct packed {
      logic valid;
      logic [7:0] value;
      logic [1:0] scale;
   } pdccr_spl_type;

   // state of the register bank except the logged error flags
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [2:0] mps_sup;
      logic rber;
      logic [7:0] spl_val;
      logic [1:0] spl_scl;
      logic [3:0] err_en;
      logic [2:0] mps;
      logic aux_en;
      logic aux_det;
   } pdccr_state_type;

   // state of one logged error flag
   typedef struct packed {
      logic flag;
   } pdccr_flag_state_type;

endpackage : pdccr_pkg

// *** pdccr_clamp.sv ***
// limits a payload size code to an upper bound
`timescale 1ns/1ps
`default_nettype none

module pdccr_clamp #(
   parameter int W = 3
) (
   input wire logic [W-1:0] val_i,
   input wire logic [W-1:0] limit_i,
   output logic [W-1:0] res_o
);

   // ****************************************************************
   // clamp
   // ****************************************************************
   // larger codes mean larger payloads, so a plain compare suffices
   always_comb begin
      res_o = (val_i > limit_i) ? limit_i : val_i;
   end

endmodule : pdccr_clamp

`default_nettype wire

// *** pdccr_flag.sv ***
// one logged error flag, set by hardware and cleared by a write of one
`timescale 1ns/1ps
`default_nettype none

module pdccr_flag
   import pdccr_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   pdccr_flag_state_type st_ff; // registered flag
   pdccr_flag_state_type nxt_st; // next flag

   // ****************************************************************
   // next state
   // ****************************************************************
   // set wins over clear so an error landing on the clear is not lost
   always_comb begin
      nxt_st = st_ff;
      if (rst_i) begin
         nxt_st.flag = RESET_VAL;
      end else if (set_i) begin
         nxt_st.flag = 1'b1;
      end else if (clr_i) begin
         nxt_st.flag = 1'b0;
      end
   end

   // reset acts even while the clock enable is low
   always_ff @(posedge clk_i) begin
      if (rst_i || ce_i) begin
         st_ff <= nxt_st;
      end
   end

   assign flag_o = st_ff.flag;

endmodule : pdccr_flag

`default_nettype wire

// *** pdccr_host.sv ***
// host side model: issues one classic wishbone cycle per toggle of go_i
`timescale 1ns/1ps
`default_nettype none

module pdccr_host
   import pdccr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_i,
   input wire logic [31:0] rd_i,
   output pdccr_wb_req_type wb_o,
   output logic [31:0] rdat_o,
   output logic done_o
);
   // ****************************************************************
   // request sequencing
   // ****************************************************************
   logic seen_ff = 1'b0; // last go level taken; not reset so bench and model stay in step
   initial done_o = 1'b0;
   // one request at a time, held until ack is sampled, then dropped for a cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_o <= '0;
      end else if (!wb_o.cyc && go_i != seen_ff) begin
         seen_ff <= go_i;
         wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we_i, adr: adr_i, sel: sel_i, dat: dat_i};
      end else if (wb_o.cyc && ack_i) begin
         // released lines show the inverse, so a stale value never looks valid
         rdat_o <= rd_i;
         done_o <= ~done_o;
         wb_o <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, adr: ~wb_o.adr, sel: 4'h0, dat: ~wb_o.dat};
      end
   end
endmodule : pdccr_host

`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the capability/control register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import pdccr_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b0;
   logic por_i = 1'b1;
   logic strap = 1'b0;
   pdccr_override_type ovr = '0;
   pdccr_spl_type spl = '0;
   logic [3:0] err_det = 4'h0;
   logic go = 1'b0;
   logic h_we = 1'b0;
   logic [7:0] h_adr = 8'h00;
   logic [3:0] h_sel = 4'h0;
   logic [31:0] h_dat = 32'h0;
   pdccr_wb_req_type wb;
   logic [31:0] dat_o, h_rdat;
   logic ack_o, done_t, aux_o;
   logic [3:0] en_o, sts_o;
   logic [2:0] mps_o, sup_o;
   logic ce = 1'b1;
   logic aux_det = 1'b1;
   logic dn_ack;
   logic [31:0] dn_dat, dn_rdat;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   // ****************************************************************
   // clock, design and host model
   // ****************************************************************
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   pdccr_top i_pdccr_top (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .ce_i(ce),
      .wb_i(wb), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .payload_512_strap_i(strap),
      .ovr_i(ovr), .spl_i(spl), .err_det_i(err_det), .aux_pwr_det_i(aux_det),
      .err_report_en_o(en_o), .max_payload_o(mps_o), .aux_pwr_en_o(aux_o),
      .mps_supported_o(sup_o), .err_status_o(sts_o));
   pdccr_host i_pdccr_host (.clk_i(clk_i), .rst_i(rst_i | por_i), .go_i(go), .we_i(h_we),
      .adr_i(h_adr), .sel_i(h_sel), .dat_i(h_dat), .ack_i(ack_o), .rd_i(dat_o), .wb_o(wb),
      .rdat_o(h_rdat), .done_o(done_t));
   // downstream copy on the same bus: it must never capture a slot power limit
   if (1) begin : g_dn
      pdccr_top #(.IS_UPSTREAM(1'b0)) i_pdccr_top (.clk_i(clk_i), .rst_i(rst_i),
         .por_i(por_i), .ce_i(ce), .wb_i(wb), .wb_dat_o(dn_dat), .wb_ack_o(dn_ack),
         .payload_512_strap_i(strap), .ovr_i(ovr), .spl_i(spl), .err_det_i(err_det),
         .aux_pwr_det_i(aux_det), .err_report_en_o(), .max_payload_o(), .aux_pwr_en_o(),
         .mps_supported_o(), .err_status_o());
   end
   // keep the downstream answer, it stands for one cycle only
   always @(posedge clk_i) begin
      if (dn_ack) begin
         dn_rdat <= dn_dat;
      end
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic complete_run;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   // a hang counts as a mismatch; the whole run needs well under this
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // one bus cycle; waits for the host model to report the ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      @(posedge clk_i);
      h_we <= w;
      h_adr <= a;
      h_sel <= s;
      h_dat <= d;
      go <= ~go;
      @(posedge clk_i);
      wait (done_t === go);
   endtask : bus
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 4'hf, 32'h0);
      chk(n, h_rdat, exp);
   endtask : rd
   // reset pulse of either kind with a chosen strap level
   task automatic do_rst(input logic p, input logic s);
      @(posedge clk_i);
      rst_i <= ~p;
      por_i <= p;
      strap <= s;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_rst

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      rd("cap", 8'hc4, 32'h0000_8001);
      rd("ctl", 8'hc8, 32'h0010_0000);
      rd("unmapped", 8'h00, 32'h0);
      do_rst(1'b0, 1'b1);
      chk("sup", 32'(sup_o), 32'h2);
   endtask : t_reset
   task automatic t_ctl;
      bus(1'b1, 8'hc8, 4'h3, 32'hffff_ffff);
      rd("ctl all", 8'hc8, 32'h0010_044f);
      chk("en", 32'(en_o), 32'hf);
      chk("aux", 32'(aux_o), 32'h1);
      bus(1'b1, 8'hc8, 4'h1, 32'h0000_0020);
      rd("ctl lane", 8'hc8, 32'h0010_0420);
      bus(1'b1, 8'hc4, 4'hf, 32'hffff_ffff);
      rd("cap ro", 8'hc4, 32'h0000_8002);
   endtask : t_ctl
   task automatic t_sticky;
      do_rst(1'b0, 1'b1);
      rd("ctl rst", 8'hc8, 32'h0010_0400);
      do_rst(1'b1, 1'b1);
      rd("ctl por", 8'hc8, 32'h0010_0000);
   endtask : t_sticky
   task automatic t_err;
      @(posedge clk_i);
      err_det <= 4'h5;
      @(posedge clk_i);
      err_det <= 4'h0;
      rd("sts", 8'hc8, 32'h0015_0000);
      bus(1'b1, 8'hc8, 4'h4, 32'h0001_0000);
      @(posedge clk_i);
      chk("sts w1c", 32'(sts_o), 32'h4);
   endtask : t_err
   task automatic t_ovr;
      @(posedge clk_i);
      ovr <= '{wr: 1'b1, mps_sup: 3'h7, rber: 1'b0};
      @(posedge clk_i);
      ovr <= '0;
      rd("cap ovr", 8'hc4, 32'h0000_0002);
      bus(1'b1, 8'hc8, 4'h1, 32'h0000_0040);
      @(posedge clk_i);
      ovr <= '{wr: 1'b1, mps_sup: 3'h1, rber: 1'b1};
      @(posedge clk_i);
      ovr <= '0;
      @(posedge clk_i);
      chk("mps", 32'(mps_o), 32'h1);
   endtask : t_ovr
   task automatic t_spl;
      @(posedge clk_i);
      spl <= '{valid: 1'b1, value: 8'ha5, scale: 2'h3};
      @(posedge clk_i);
      spl <= '{valid: 1'b1, value: 8'h3c, scale: 2'h1};
      @(posedge clk_i);
      spl <= '0;
      rd("spl", 8'hc4, 32'h04f0_8001);
      @(posedge clk_i);
      chk("spl dn", dn_rdat, 32'h0000_8001);
   endtask : t_spl
   // low enable freezes state, reset still acts; set wins over a clear
   task automatic t_ce;
      @(posedge clk_i);
      ce <= 1'b0;
      aux_det <= 1'b0;
      spl <= '{valid: 1'b1, value: 8'h11, scale: 2'h2};
      err_det <= 4'ha;
      ovr <= '{wr: 1'b1, mps_sup: 3'h2, rber: 1'b0};
      @(posedge clk_i);
      spl <= '0;
      err_det <= 4'h0;
      ovr <= '0;
      @(posedge clk_i);
      ce <= 1'b1;
      rd("cap frz", 8'hc4, 32'h04f0_8001);
      rd("ctl frz", 8'hc8, 32'h0004_0020);
      err_det <= 4'ha;
      bus(1'b1, 8'hc8, 4'h4, 32'h0002_0000);
      err_det <= 4'h0;
      repeat (2) @(posedge clk_i);
      chk("sts set wins", 32'(sts_o), 32'he);
      ce <= 1'b0;
      do_rst(1'b0, 1'b0);
      chk("sup ce low", 32'(sup_o), 32'h1);
      chk("sts ce low", 32'(sts_o), 32'h0);
      ce <= 1'b1;
   endtask : t_ce

   // ****************************************************************
   // main sequence: power-on reset held 6 cycles, then scenarios
   // ****************************************************************
   initial begin
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      t_reset();
      t_ctl();
      t_sticky();
      t_err();
      t_ovr();
      t_spl();
      t_ce();
      complete_run();
   end
endmodule : tb_top

`default_nettype wire
